// >>> core/subtract_borrow_literal_exec.v
// Execution unit for the reverse subtract with borrow and the literal-minus-accumulator instructions.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "sbl_map.vh"

// How it works
// - Reverse form computes acc minus operand minus not-borrow.
// - Target bit zero writes acc, one writes memory.
// - Bank bit selects access bank or bank_pointer bank.
// - Access bank, extended set, operand <=95: indexed.
// - Negative result: msb set, null clear, borrow clear.
// - Zero result: null set, msb clear, borrow set.
// - Positive result: msb, null clear; borrow set.
// - Literal form computes literal minus accumulator.
// - Literal form writes acc, updates five flags.
module subtract_borrow_literal_exec #(
  parameter DATA_W = 8,
  parameter BANK_W = 4
) (
  input  wire                   SYS_CLK,
  input  wire                   RST_N,
  input  wire [15:0]            INSTR_WORD,
  input  wire                   INSTR_VALID,
  output wire                   INSTR_READY,
  output reg                    INSTR_DONE,
  output reg                    INSTR_UNKNOWN,
  output reg  [`SBL_ADDR_W-1:0] MEM_ADDR,
  output wire                   MEM_RD_STB,
  input  wire [DATA_W-1:0]      MEM_RD_DATA,
  output wire                   MEM_WR_STB,
  output reg  [DATA_W-1:0]      MEM_WR_DATA,
  input  wire [2:0]             REG_ADDR,
  input  wire [DATA_W-1:0]      REG_WDATA,
  input  wire                   REG_WR,
  input  wire                   REG_RD,
  output reg  [DATA_W-1:0]      REG_RDATA
);

  // ==========================================================================
  // State
  // ==========================================================================
  reg  [1:0]             phase_reg;
  reg  [1:0]             phase_next;
  reg                    is_rsb_reg;
  reg                    to_mem_reg;
  reg  [DATA_W-1:0]      literal_reg;
  reg  [DATA_W-1:0]      acc_reg;
  reg  [4:0]             status_reg;
  reg  [BANK_W-1:0]      bank_pointer_reg;
  reg                    ext_enable_reg;
  reg  [`SBL_ADDR_W-1:0] index_base_reg;
  reg  [DATA_W-1:0]      result_reg;
  reg  [4:0]             flags_reg;

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire accept;
  wire dec_rsb;
  wire dec_lit;
  wire bank_mode;
  wire [7:0] operand_field;
  reg  [`SBL_ADDR_W-1:0] eff_addr;

  assign INSTR_READY   = (phase_reg == `SBL_PH_IDLE);
  assign accept        = INSTR_VALID && INSTR_READY;
  assign dec_rsb       = (INSTR_WORD[`SBL_OP_RSB_MSB:`SBL_OP_RSB_LSB] == `SBL_OP_RSB_TOP);
  assign dec_lit       = (INSTR_WORD[`SBL_OP_LIT_MSB:`SBL_OP_LIT_LSB] == `SBL_OP_LIT_TOP);
  assign bank_mode     = INSTR_WORD[`SBL_BIT_BANKMODE];
  assign operand_field = INSTR_WORD[7:0];

  // The operand address is resolved during decode, so a bank_pointer write
  // later in the same instruction cannot move the access.
  always @* begin
    if (bank_mode) begin
      eff_addr = {bank_pointer_reg, operand_field};
    end else if (ext_enable_reg && (operand_field <= `SBL_INDEX_MAX)) begin
      eff_addr = index_base_reg + {4'h0, operand_field};
    end else if (operand_field <= `SBL_INDEX_MAX) begin
      eff_addr = {`SBL_ACCESS_LOW_PAGE, operand_field};
    end else begin
      eff_addr = {`SBL_ACCESS_HI_PAGE, operand_field};
    end
  end

  // ==========================================================================
  // Phase sequencer
  // ==========================================================================
  always @* begin
    case (phase_reg)
      `SBL_PH_IDLE: begin
        if (accept && (dec_rsb || dec_lit)) begin
          phase_next = `SBL_PH_READ;
        end else begin
          phase_next = `SBL_PH_IDLE;
        end
      end
      `SBL_PH_READ:  phase_next = `SBL_PH_PROC;
      `SBL_PH_PROC:  phase_next = `SBL_PH_WRITE;
      `SBL_PH_WRITE: phase_next = `SBL_PH_IDLE;
      default:       phase_next = `SBL_PH_IDLE;
    endcase
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_reg <= `SBL_PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ==========================================================================
  // Arithmetic
  // ==========================================================================
  wire [DATA_W-1:0] sub_a;
  wire [DATA_W-1:0] sub_b;
  wire              sub_cin;
  wire [DATA_W-1:0] sub_diff;
  wire              sub_carry;
  wire              sub_nibble;
  wire              sub_wrap;
  wire              sub_msb;
  wire              sub_zero;

  // Reverse form: acc - operand - !borrow; literal form: literal - acc.
  assign sub_a   = is_rsb_reg ? acc_reg : literal_reg;
  assign sub_b   = is_rsb_reg ? MEM_RD_DATA : acc_reg;
  assign sub_cin = is_rsb_reg ? status_reg[`SBL_ST_BORROW] : 1'b1;

  sbl_sub_flags #(
    .WIDTH (DATA_W)
  ) u_sub (
    .minuend      (sub_a),
    .subtrahend   (sub_b),
    .carry_in     (sub_cin),
    .difference   (sub_diff),
    .carry_out    (sub_carry),
    .nibble_carry (sub_nibble),
    .sign_wrap    (sub_wrap),
    .msb_out      (sub_msb),
    .is_zero      (sub_zero)
  );

  // ==========================================================================
  // Instruction datapath
  // ==========================================================================
  assign MEM_RD_STB = (phase_reg == `SBL_PH_READ) && is_rsb_reg;
  assign MEM_WR_STB = (phase_reg == `SBL_PH_WRITE) && to_mem_reg;

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      is_rsb_reg    <= 1'b0;
      to_mem_reg    <= 1'b0;
      literal_reg   <= {DATA_W{1'b0}};
      MEM_ADDR      <= {`SBL_ADDR_W{1'b0}};
      result_reg    <= {DATA_W{1'b0}};
      flags_reg     <= `SBL_RST_STATUS;
      MEM_WR_DATA   <= {DATA_W{1'b0}};
      INSTR_DONE    <= 1'b0;
      INSTR_UNKNOWN <= 1'b0;
    end else begin
      INSTR_DONE    <= (phase_reg == `SBL_PH_PROC);
      INSTR_UNKNOWN <= accept && !dec_rsb && !dec_lit;
      if (accept) begin
        is_rsb_reg  <= dec_rsb;
        to_mem_reg  <= dec_rsb && INSTR_WORD[`SBL_BIT_TARGET];
        literal_reg <= INSTR_WORD[7:0];
        MEM_ADDR    <= eff_addr;
      end
      if (phase_reg == `SBL_PH_PROC) begin
        result_reg  <= sub_diff;
        MEM_WR_DATA <= sub_diff;
        // Carry out of the inverted-subtrahend add is the borrow_bit: set
        // means no borrow, which covers the zero and positive cases.
        flags_reg[`SBL_ST_BORROW] <= sub_carry;
        flags_reg[`SBL_ST_NIBBLE] <= sub_nibble;
        flags_reg[`SBL_ST_NULL]   <= sub_zero;
        flags_reg[`SBL_ST_WRAP]   <= sub_wrap;
        flags_reg[`SBL_ST_MSB]    <= sub_msb;
      end
    end
  end

  // ==========================================================================
  // Software registers
  // ==========================================================================
  wire commit;
  wire sw_wr_acc;
  wire sw_wr_status;

  // The instruction commit outranks a software write landing in the same cycle.
  assign commit       = (phase_reg == `SBL_PH_WRITE);
  assign sw_wr_acc    = REG_WR && (REG_ADDR == `SBL_REG_ACC);
  assign sw_wr_status = REG_WR && (REG_ADDR == `SBL_REG_STATUS);

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_reg          <= `SBL_RST_ACC;
      status_reg       <= `SBL_RST_STATUS;
      bank_pointer_reg <= `SBL_RST_BANK;
      ext_enable_reg   <= 1'b0;
      index_base_reg   <= `SBL_RST_IDX;
    end else begin
      if (commit && !to_mem_reg) begin
        acc_reg <= result_reg;
      end else if (sw_wr_acc) begin
        acc_reg <= REG_WDATA;
      end
      if (commit) begin
        status_reg <= flags_reg;
      end else if (sw_wr_status) begin
        status_reg <= REG_WDATA[4:0];
      end
      if (REG_WR && (REG_ADDR == `SBL_REG_BANK)) begin
        bank_pointer_reg <= REG_WDATA[BANK_W-1:0];
      end
      if (REG_WR && (REG_ADDR == `SBL_REG_CONFIG)) begin
        ext_enable_reg <= REG_WDATA[`SBL_CFG_EXT];
      end
      if (REG_WR && (REG_ADDR == `SBL_REG_IDX_LO)) begin
        index_base_reg[7:0] <= REG_WDATA;
      end
      if (REG_WR && (REG_ADDR == `SBL_REG_IDX_HI)) begin
        index_base_reg[`SBL_ADDR_W-1:8] <= REG_WDATA[3:0];
      end
    end
  end

  // Read data stands only in the cycle after the strobe and is zero otherwise.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= {DATA_W{1'b0}};
    end else if (REG_RD) begin
      case (REG_ADDR)
        `SBL_REG_ACC:    REG_RDATA <= acc_reg;
        `SBL_REG_STATUS: REG_RDATA <= {3'h0, status_reg};
        `SBL_REG_BANK:   REG_RDATA <= {{(DATA_W-BANK_W){1'b0}}, bank_pointer_reg};
        `SBL_REG_CONFIG: REG_RDATA <= {7'h00, ext_enable_reg};
        `SBL_REG_IDX_LO: REG_RDATA <= index_base_reg[7:0];
        `SBL_REG_IDX_HI: REG_RDATA <= {4'h0, index_base_reg[`SBL_ADDR_W-1:8]};
        `SBL_REG_PHASE:  REG_RDATA <= {6'h00, phase_reg};
        default:         REG_RDATA <= {DATA_W{1'b0}};
      endcase
    end else begin
      REG_RDATA <= {DATA_W{1'b0}};
    end
  end

endmodule // subtract_borrow_literal_exec

// >>> common/sbl_map.vh
// Constant map for the subtract-with-borrow and literal-subtract execution block.
`ifndef SBL_MAP_VH
`define SBL_MAP_VH

// ==========================================================================
// Instruction decode
// ==========================================================================
`define SBL_OP_RSB_TOP      6'h15
`define SBL_OP_RSB_MSB      15
`define SBL_OP_RSB_LSB      10
`define SBL_OP_LIT_TOP      8'h08
`define SBL_OP_LIT_MSB      15
`define SBL_OP_LIT_LSB      8
`define SBL_BIT_TARGET      9
`define SBL_BIT_BANKMODE    8

// ==========================================================================
// Data-memory addressing
// ==========================================================================
`define SBL_ADDR_W          12
`define SBL_INDEX_MAX       8'h5F
`define SBL_ACCESS_LOW_PAGE 4'h0
`define SBL_ACCESS_HI_PAGE  4'hF

// ==========================================================================
// Phase codes
// ==========================================================================
`define SBL_PH_IDLE         2'h0
`define SBL_PH_READ         2'h1
`define SBL_PH_PROC         2'h2
`define SBL_PH_WRITE        2'h3

// ==========================================================================
// Register port map and status bit positions
// ==========================================================================
`define SBL_REG_ACC         3'h0
`define SBL_REG_STATUS      3'h1
`define SBL_REG_BANK        3'h2
`define SBL_REG_CONFIG      3'h3
`define SBL_REG_IDX_LO      3'h4
`define SBL_REG_IDX_HI      3'h5
`define SBL_REG_PHASE       3'h6
`define SBL_ST_BORROW       0
`define SBL_ST_NIBBLE       1
`define SBL_ST_NULL         2
`define SBL_ST_WRAP         3
`define SBL_ST_MSB          4
`define SBL_CFG_EXT         0
`define SBL_RST_ACC         8'h00
`define SBL_RST_STATUS      5'h00
`define SBL_RST_BANK        4'h0
`define SBL_RST_IDX         12'h000

`endif

// >>> core/sbl_sub_flags.v
// Two's complement subtractor that also derives the arithmetic status flags.
`timescale 1ns/10ps
`include "sbl_map.vh"

module sbl_sub_flags #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0] minuend,
  input  wire [WIDTH-1:0] subtrahend,
  input  wire             carry_in,
  output wire [WIDTH-1:0] difference,
  output wire             carry_out,
  output wire             nibble_carry,
  output wire             sign_wrap,
  output wire             msb_out,
  output wire             is_zero
);

  wire [WIDTH:0] full_sum;
  wire [4:0]     low_sum;

  // A borrow is the absence of carry when adding the inverted subtrahend.
  assign full_sum     = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, carry_in};
  assign low_sum      = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
  assign difference   = full_sum[WIDTH-1:0];
  assign carry_out    = full_sum[WIDTH];
  assign nibble_carry = low_sum[4];
  assign sign_wrap    = (minuend[WIDTH-1] != subtrahend[WIDTH-1]) && (difference[WIDTH-1] != minuend[WIDTH-1]);
  assign msb_out      = difference[WIDTH-1];
  assign is_zero      = (difference == {WIDTH{1'b0}});

endmodule // sbl_sub_flags

// >>> bench/subtract_borrow_literal_exec_sva.sv
// Port-level concurrent checks for the subtract execution block.
`timescale 1ns/10ps
`include "sbl_map.vh"

// ==========================================================================
// Checker
// ==========================================================================
module subtract_borrow_literal_exec_sva #(
  parameter DATA_W = 8,
  parameter BANK_W = 4
) (
  input wire                   SYS_CLK,
  input wire                   RST_N,
  input wire [15:0]            INSTR_WORD,
  input wire                   INSTR_VALID,
  input wire                   INSTR_READY,
  input wire                   INSTR_DONE,
  input wire                   INSTR_UNKNOWN,
  input wire [`SBL_ADDR_W-1:0] MEM_ADDR,
  input wire                   MEM_RD_STB,
  input wire [DATA_W-1:0]      MEM_RD_DATA,
  input wire                   MEM_WR_STB,
  input wire [DATA_W-1:0]      MEM_WR_DATA,
  input wire [2:0]             REG_ADDR,
  input wire [DATA_W-1:0]      REG_WDATA,
  input wire                   REG_WR,
  input wire                   REG_RD,
  input wire [DATA_W-1:0]      REG_RDATA
);
  wire take     = INSTR_VALID && INSTR_READY;
  wire rsb_take = take && (INSTR_WORD[`SBL_OP_RSB_MSB:`SBL_OP_RSB_LSB] == `SBL_OP_RSB_TOP);
  wire lit_take = take && (INSTR_WORD[`SBL_OP_LIT_MSB:`SBL_OP_LIT_LSB] == `SBL_OP_LIT_TOP);
  wire bad_take = take && !rsb_take && !lit_take;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  done_in_q4_a: assert property ((rsb_take || lit_take) |-> ##3 INSTR_DONE)
    else $error("done pulse missing in fourth cycle");
  busy_window_a: assert property ((rsb_take || lit_take) |=> !INSTR_READY [*3] ##1 INSTR_READY)
    else $error("ready window wrong");
  operand_read_a: assert property (rsb_take |=> MEM_RD_STB ##1 !MEM_RD_STB)
    else $error("operand read strobe wrong");
  literal_no_mem_a: assert property (lit_take |=> (!MEM_RD_STB && !MEM_WR_STB) [*3])
    else $error("literal form touched memory");
  target_write_a: assert property (rsb_take |->
    ##3 (MEM_WR_STB == $past(INSTR_WORD[`SBL_BIT_TARGET], 3)))
    else $error("write strobe disagrees with target bit");
  access_high_a: assert property (rsb_take && !INSTR_WORD[`SBL_BIT_BANKMODE] && (INSTR_WORD[7:0] > `SBL_INDEX_MAX) |=>
    MEM_ADDR == {`SBL_ACCESS_HI_PAGE, $past(INSTR_WORD[7:0])}) else $error("access bank upper address wrong");
  unknown_pulse_a: assert property (bad_take |=> INSTR_UNKNOWN && INSTR_READY)
    else $error("unknown word not flagged");
  unknown_cause_a: assert property (INSTR_UNKNOWN |-> $past(bad_take))
    else $error("unknown flag without cause");
endmodule // subtract_borrow_literal_exec_sva

bind subtract_borrow_literal_exec subtract_borrow_literal_exec_sva #(.DATA_W(DATA_W), .BANK_W(BANK_W)) i_sva (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .INSTR_WORD(INSTR_WORD), .INSTR_VALID(INSTR_VALID),
  .INSTR_READY(INSTR_READY), .INSTR_DONE(INSTR_DONE), .INSTR_UNKNOWN(INSTR_UNKNOWN), .MEM_ADDR(MEM_ADDR),
  .MEM_RD_STB(MEM_RD_STB), .MEM_RD_DATA(MEM_RD_DATA), .MEM_WR_STB(MEM_WR_STB), .MEM_WR_DATA(MEM_WR_DATA),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

// >>> bench/test_subtract_borrow_literal_exec.sv
// Self-checking bench for the subtract execution block.
`timescale 1ns/10ps
`include "sbl_map.vh"

// ==========================================================================
// Bench top
// ==========================================================================
module test_subtract_borrow_literal_exec;
  reg         sys_clk, rst_n, instr_valid, reg_wr, reg_rd;
  reg  [15:0] instr_word;
  reg  [7:0]  mem_rd_data, reg_wdata, rv;
  reg  [2:0]  reg_addr;
  reg  [63:0] r;
  wire        instr_ready, instr_done, instr_unknown, mem_rd_stb, mem_wr_stb;
  wire [11:0] mem_addr;
  wire [7:0]  mem_wr_data, reg_rdata;
  integer     failures, tests_run, cycles, i;

  subtract_borrow_literal_exec i_subtract_borrow_literal_exec (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .INSTR_WORD(instr_word), .INSTR_VALID(instr_valid),
    .INSTR_READY(instr_ready), .INSTR_DONE(instr_done), .INSTR_UNKNOWN(instr_unknown), .MEM_ADDR(mem_addr),
    .MEM_RD_STB(mem_rd_stb), .MEM_RD_DATA(mem_rd_data), .MEM_WR_STB(mem_wr_stb), .MEM_WR_DATA(mem_wr_data),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

  // ========================================================================
  // Expectation functions
  // ========================================================================
  // Returns {msb, wrap, null, nibble, borrow, result}; borrow high means none occurred.
  function [12:0] sub8(input [7:0] a, input [7:0] b, input ci);
    reg [8:0] s;
    reg [4:0] n;
    begin
      s = {1'b0, a} + {1'b0, ~b} + {8'h00, ci};
      n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
      sub8 = {s[7], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, n[4], s[8], s[7:0]};
    end
  endfunction

  function [11:0] addr_of(input [7:0] f, input a, input [3:0] bank, input ext, input [11:0] ib);
    addr_of = a ? {bank, f} : (f <= 8'h5F) ? (ext ? ib + {4'h0, f} : {4'h0, f}) : {4'hF, f};
  endfunction

  // ========================================================================
  // Tasks
  // ========================================================================
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task close_out;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask

  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge sys_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk); reg_wr <= 1'b0;
    end
  endtask

  task rd(input [2:0] a);
    begin
      @(posedge sys_clk); reg_rd <= 1'b1; reg_addr <= a;
      @(posedge sys_clk); reg_rd <= 1'b0;
      #1 rv = reg_rdata;
    end
  endtask

  // Memory data is valid only in the processing cycle; from the write cycle on it shows the inverse.
  task run(input [15:0] w, input [7:0] op, input [12:0] e, input [11:0] ad, input rsb, input [7:0] av);
    begin
      @(posedge sys_clk); instr_valid <= 1'b1; instr_word <= w;
      @(posedge sys_clk); instr_valid <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= `SBL_REG_PHASE;
      #1 check(mem_rd_stb, rsb);
      if (rsb) check(mem_addr, ad);
      @(posedge sys_clk); mem_rd_data <= op;
      reg_rd <= 1'b0;
      #1 check(reg_rdata, {6'h00, `SBL_PH_READ});
      @(posedge sys_clk); mem_rd_data <= ~op;
      #1 check(instr_done, 1);
      check(mem_wr_stb, rsb && w[9]);
      if (rsb && w[9]) check(mem_wr_data, e[7:0]);
      @(posedge sys_clk);
      #1 check(instr_ready, 1);
      rd(`SBL_REG_STATUS); check(rv, e[12:8]);
      rd(`SBL_REG_ACC); check(rv, (rsb && w[9]) ? av : e[7:0]);
    end
  endtask

  task one(input lit, input [7:0] acc, input [7:0] op, input c, input [7:0] f, input d, input a,
           input [3:0] bank, input ext, input [11:0] ib);
    begin
      wr(`SBL_REG_ACC, acc); wr(`SBL_REG_STATUS, {7'h00, c}); wr(`SBL_REG_BANK, {4'h0, bank});
      wr(`SBL_REG_CONFIG, {7'h00, ext}); wr(`SBL_REG_IDX_LO, ib[7:0]); wr(`SBL_REG_IDX_HI, {4'h0, ib[11:8]});
      if (lit) run({8'h08, op}, op, sub8(op, acc, 1'b1), 12'h000, 1'b0, acc);
      else run({6'h15, d, a, f}, op, sub8(acc, op, c), addr_of(f, a, bank, ext, ib), 1'b1, acc);
    end
  endtask

  // ========================================================================
  // Clock, timeout and main sequence
  // ========================================================================
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      close_out;
    end
  end

  initial begin
    failures = 0; tests_run = 0; cycles = 0; rst_n = 1'b0; instr_valid = 1'b0; instr_word = 16'h0000;
    reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0; reg_wdata = 8'h00; mem_rd_data = 8'hA5;
    r[31:0] = $urandom(32'h576D0A57);
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rd(i[2:0]); check(rv, 8'h00);
    end
    wr(3'h6, 8'hFF); rd(3'h6); check(rv, 8'h00);
    // A near neighbour of the reverse subtract pattern must be refused.
    @(posedge sys_clk); instr_valid <= 1'b1; instr_word <= 16'h5C12;
    @(posedge sys_clk); instr_valid <= 1'b0;
    #1 check(instr_unknown, 1);
    one(1'b0, 8'h02, 8'h03, 1'b1, 8'h60, 1'b1, 1'b0, 4'h0, 1'b0, 12'h000);
    one(1'b0, 8'h05, 8'h02, 1'b1, 8'h5F, 1'b0, 1'b0, 4'h3, 1'b1, 12'hFF0);
    one(1'b0, 8'h02, 8'h01, 1'b0, 8'h5F, 1'b1, 1'b0, 4'h3, 1'b0, 12'hFF0);
    one(1'b0, 8'h80, 8'h01, 1'b1, 8'h21, 1'b0, 1'b1, 4'hC, 1'b1, 12'h123);
    for (i = 1; i < 4; i = i + 1) one(1'b1, i[7:0], 8'h02, 1'b0, 8'h00, 1'b0, 1'b0, 4'h0, 1'b0, 12'h000);
    repeat (60) begin
      r = {$urandom, $urandom};
      one(r[0], r[8:1], r[16:9], r[17], r[25:18], r[26], r[27], r[31:28], r[32], r[44:33]);
    end
    close_out;
  end
endmodule // test_subtract_borrow_literal_exec
